// ### src/seq_cfg_pkg.sv
/*
  Constants for the step-7 and step-8 sequencer configuration registers of the
  multiplexed converter: offsets, field positions, reset values and codes.
  Assumes the serial framing outside delivers decoded register reads and writes.
*/
package seq_cfg_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] STEP7_ADDR = 8'h97;
  localparam logic [ADDR_W-1:0] STEP8_ADDR = 8'h98;
  localparam logic [DATA_W-1:0] STEP7_RESET = 16'h0007;
  localparam logic [DATA_W-1:0] STEP8_RESET = 16'h0008;
  // writable bits: enable, gain, negative select, positive select
  localparam logic [DATA_W-1:0] WRITE_MASK = 16'hE01F;
  localparam int EN_BIT = 15;
  localparam int GAIN_HI = 14;
  localparam int GAIN_LO = 13;
  localparam int NEG_BIT = 4;
  localparam int POS_HI = 3;
  localparam int POS_LO = 0;
  localparam int POS_INTERNAL_BIT = 3;
  // gain factor on the output, as a plain multiplier
  localparam logic [2:0] GAIN_X1 = 3'h1;
  localparam logic [2:0] GAIN_X2 = 3'h2;
  localparam logic [2:0] GAIN_X4 = 3'h4;
  localparam logic [1:0] GAIN_CODE_X1 = 2'h0;
  localparam logic [1:0] GAIN_CODE_X2 = 2'h1;
  // effective negative input routing
  localparam logic [1:0] NEG_GROUND = 2'h0;
  localparam logic [1:0] NEG_AIN7 = 2'h1;
  localparam logic [1:0] NEG_AUTO = 2'h2;
endpackage

// ### src/seq_step_cfg.sv
/*
  Step-7 and step-8 sequencer configuration registers with the decoded step-7
  settings for the sequencer and input multiplexer. Writes land one edge after
  the strobe and the decoded outputs one edge later; reads answer one edge
  after the strobe with a single-cycle valid.
  Assumes register requests come from logic on clk, at most one strobe of
  each kind per cycle, and that arst_n may fall at any time.
*/
`timescale 1ns/1ps
module seq_step_cfg (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [seq_cfg_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [seq_cfg_pkg::DATA_W-1:0] reg_wdata,
  output logic [seq_cfg_pkg::DATA_W-1:0] reg_rdata,
  output logic reg_rvalid,
  output logic step7_enable,
  output logic step7_skip,
  output logic [2:0] step7_gain,
  output logic [3:0] step7_positive_input_select,
  output logic [1:0] step7_negative_input_select,
  output logic [seq_cfg_pkg::DATA_W-1:0] step8_config
);
  import seq_cfg_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // reset release: asynchronous assert, two-flop synchronous release
  // every other flop resets from rst_n_q, so the whole block leaves reset
  // on one edge even when arst_n lifts right beside a clock edge
  logic rst_meta_q;
  logic rst_n_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // address decode and masked write data
  logic [DATA_W-1:0] step7_q;
  logic [DATA_W-1:0] step7_d;
  logic [DATA_W-1:0] step8_q;
  logic [DATA_W-1:0] step8_d;
  wire hit7 = reg_addr == STEP7_ADDR;
  wire hit8 = reg_addr == STEP8_ADDR;
  // reserved bits never reach storage, so reads need no second mask
  wire [DATA_W-1:0] wdata_masked = reg_wdata & WRITE_MASK;
  assign step7_d = (reg_wr && hit7) ? wdata_masked : step7_q;
  assign step8_d = (reg_wr && hit8) ? wdata_masked : step8_q;

  // configuration storage, held at its reset words until rst_n_q rises
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      step7_q <= STEP7_RESET;
      step8_q <= STEP8_RESET;
    end else begin
      step7_q <= step7_d;
      step8_q <= step8_d;
    end
  end

  // both words sit at their reset values on the first live edge
  chk_reset_word: assert property (@(posedge clk) disable iff (!rst_n_q)
    $rose(rst_n_q) |-> step7_q == STEP7_RESET && step8_q == STEP8_RESET)
    else $error("register not at reset word after release");

  // reserved bits hold zero in both words
  chk_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n_q)
    (step7_q & ~WRITE_MASK) == '0 && (step8_q & ~WRITE_MASK) == '0)
    else $error("reserved bits not zero");

  // a write to either word lands on the next edge, masked
  chk_write_lands: assert property (@(posedge clk) disable iff (!rst_n_q)
    reg_wr && hit7 |=> step7_q == $past(reg_wdata & WRITE_MASK))
    else $error("step7 write lost");
  chk_step8_write: assert property (@(posedge clk) disable iff (!rst_n_q)
    reg_wr && hit8 |=> step8_q == $past(reg_wdata & WRITE_MASK))
    else $error("step8 write lost");

  // nothing but a matching write moves a stored word
  chk_step7_quiet: assert property (@(posedge clk) disable iff (!rst_n_q)
    !(reg_wr && hit7) |=> step7_q == $past(step7_q))
    else $error("step7 changed without a write");
  chk_step8_quiet: assert property (@(posedge clk) disable iff (!rst_n_q)
    !(reg_wr && hit8) |=> step8_q == $past(step8_q))
    else $error("step8 changed without a write");

  ////////////////////////////////////////////////////////////////////////////
  // read path: unmapped addresses return zero rather than stale data
  wire [DATA_W-1:0] rd_mux = hit7 ? step7_q : (hit8 ? step8_q : '0);
  // rdata idles at zero between answers; costs a mux, keeps the bus quiet
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      reg_rdata <= '0;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : '0;
      reg_rvalid <= reg_rd;
    end
  end

  // read answers carry the addressed word one edge after the strobe
  chk_step7_readback: assert property (@(posedge clk) disable iff (!rst_n_q)
    reg_rd && hit7 && !reg_wr |=> reg_rvalid && reg_rdata == $past(step7_q))
    else $error("step7 readback wrong");

  // a write in the same cycle does not show through to the read
  chk_readwrite_old: assert property (@(posedge clk) disable iff (!rst_n_q)
    reg_rd && reg_wr && hit7 |=> reg_rdata == $past(step7_q))
    else $error("same-cycle read saw new data");
  chk_step8_readback: assert property (@(posedge clk) disable iff (!rst_n_q)
    reg_rd && hit8 |=> reg_rvalid && reg_rdata == $past(step8_q))
    else $error("step8 readback wrong");
  chk_unmapped_zero: assert property (@(posedge clk) disable iff (!rst_n_q)
    reg_rd && !hit7 && !hit8 |=> reg_rvalid && reg_rdata == '0)
    else $error("unmapped read not zero");

  // valid strobes once per read and data idles at zero between answers
  chk_rvalid_pulse: assert property (@(posedge clk) disable iff (!rst_n_q)
    $past(rst_n_q) |-> reg_rvalid == $past(reg_rd))
    else $error("read valid not one cycle after strobe");
  chk_rdata_idle: assert property (@(posedge clk) disable iff (!rst_n_q)
    !reg_rvalid |-> reg_rdata == '0)
    else $error("read data not idle at zero");
  chk_reserved_read: assert property (@(posedge clk) disable iff (!rst_n_q)
    (reg_rdata & ~WRITE_MASK) == '0)
    else $error("reserved bits read nonzero");

  ////////////////////////////////////////////////////////////////////////////
  // field decode from the stored step-7 word
  wire en_bit = step7_q[EN_BIT];
  wire [1:0] gain_code = step7_q[GAIN_HI:GAIN_LO];
  wire [3:0] pos_code = step7_q[POS_HI:POS_LO];
  wire pos_internal = pos_code[POS_INTERNAL_BIT];
  // 10b and 11b both land on gain 4
  wire [2:0] gain_factor = (gain_code == GAIN_CODE_X1) ? GAIN_X1 :
                           (gain_code == GAIN_CODE_X2) ? GAIN_X2 : GAIN_X4;
  // internal sources pick their own negative, so the bit is dropped here
  wire [1:0] neg_route = pos_internal ? NEG_AUTO :
                         (step7_q[NEG_BIT] ? NEG_AIN7 : NEG_GROUND);

  // outputs registered one cycle behind the stored word; reset values
  // match the decode of the step-7 reset word, so the two never disagree
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      step7_enable <= STEP7_RESET[EN_BIT];
      step7_skip <= !STEP7_RESET[EN_BIT];
      step7_gain <= GAIN_X1;
      step7_positive_input_select <= STEP7_RESET[POS_HI:POS_LO];
      step7_negative_input_select <= NEG_GROUND;
      step8_config <= STEP8_RESET;
    end else begin
      step7_enable <= en_bit;
      step7_skip <= !en_bit;
      step7_gain <= gain_factor;
      step7_positive_input_select <= pos_code;
      step7_negative_input_select <= neg_route;
      step8_config <= step8_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decoded output checks
  // outputs leave reset showing the decode of the reset words
  chk_reset_outputs: assert property (@(posedge clk) disable iff (!rst_n_q)
    $rose(rst_n_q) |-> step7_enable == STEP7_RESET[EN_BIT] && step7_gain == GAIN_X1
      && step7_positive_input_select == STEP7_RESET[POS_HI:POS_LO]
      && step7_negative_input_select == NEG_GROUND && step8_config == STEP8_RESET)
    else $error("outputs not at reset decode after release");

  // enable reaches the sequencer two edges after the write strobe
  chk_enable_follows: assert property (@(posedge clk) disable iff (!rst_n_q)
    reg_wr && hit7 |-> ##2 step7_enable == $past(reg_wdata[EN_BIT], 2))
    else $error("enable not applied");
  chk_enable_stored: assert property (@(posedge clk) disable iff (!rst_n_q)
    $past(rst_n_q) |-> step7_enable == $past(en_bit))
    else $error("enable does not follow stored bit");

  // skip is always the inverse of enable and follows the stored bit
  chk_skip_inverse: assert property (@(posedge clk) disable iff (!rst_n_q)
    step7_skip != step7_enable)
    else $error("skip and enable disagree");
  chk_skip_follows: assert property (@(posedge clk) disable iff (!rst_n_q)
    $past(rst_n_q) |-> step7_skip == !$past(step7_q[EN_BIT]))
    else $error("skip does not follow disabled step");

  // gain codes 10b and 11b both give gain 4, 00b gain 1, 01b gain 2
  chk_gain_map: assert property (@(posedge clk) disable iff (!rst_n_q)
    $past(rst_n_q) && $past(gain_code[1]) |-> step7_gain == GAIN_X4)
    else $error("gain code 1x not gain 4");
  chk_gain_one: assert property (@(posedge clk) disable iff (!rst_n_q)
    $past(rst_n_q) && $past(gain_code) == GAIN_CODE_X1 |-> step7_gain == GAIN_X1)
    else $error("gain code 00b not gain 1");
  chk_gain_two: assert property (@(posedge clk) disable iff (!rst_n_q)
    $past(rst_n_q) && $past(gain_code) == GAIN_CODE_X2 |-> step7_gain == GAIN_X2)
    else $error("gain code 01b not gain 2");

  // internal sources force the automatic negative, the stored bit ignored
  chk_neg_auto: assert property (@(posedge clk) disable iff (!rst_n_q)
    $past(rst_n_q) && step7_positive_input_select[POS_INTERNAL_BIT]
      |-> step7_negative_input_select == NEG_AUTO)
    else $error("internal source without auto negative");

  // external sources use the stored negative bit and never the automatic one
  chk_neg_external: assert property (@(posedge clk) disable iff (!rst_n_q)
    $past(rst_n_q) && !$past(pos_internal)
      |-> step7_negative_input_select == {1'b0, $past(step7_q[NEG_BIT])})
    else $error("negative select wrong");
  chk_pos_external: assert property (@(posedge clk) disable iff (!rst_n_q)
    $past(rst_n_q) && !step7_positive_input_select[POS_INTERNAL_BIT]
      |-> step7_negative_input_select != NEG_AUTO)
    else $error("external source with auto negative");

  // positive code passes through unchanged
  chk_pos_follows: assert property (@(posedge clk) disable iff (!rst_n_q)
    $past(rst_n_q) |-> step7_positive_input_select == $past(pos_code))
    else $error("positive select stale");

  // step-8 word exported exactly as stored
  chk_step8_out: assert property (@(posedge clk) disable iff (!rst_n_q)
    $past(rst_n_q) |-> step8_config == $past(step8_q))
    else $error("step8 output stale");
endmodule

// ### test/seq_step_cfg_test.sv
/*
  Self-checking bench for the step-7/step-8 sequencer configuration block.
  Assumes the package constants and the one-cycle strobe access of the block.
*/
`timescale 1ns/1ps
module seq_step_cfg_test;
  import seq_cfg_pkg::*;
  logic clk, arst_n, reg_wr, reg_rd, reg_rvalid, step7_enable, step7_skip;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, step8_config, w;
  logic [2:0] step7_gain;
  logic [3:0] step7_positive_input_select;
  logic [1:0] step7_negative_input_select;
  int n_mismatch, total_checks;
  seq_step_cfg DUT (.clk(clk), .arst_n(arst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .step7_enable(step7_enable), .step7_skip(step7_skip), .step7_gain(step7_gain),
    .step7_positive_input_select(step7_positive_input_select),
    .step7_negative_input_select(step7_negative_input_select), .step8_config(step8_config));
  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // write, then let the two-edge decode latency pass before looking
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  // bounded wait for the read answer, rdata stands one cycle only
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    while (reg_rvalid !== 1'b1 && n < 4) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 4) begin
      n_mismatch++;
      end_sim();
    end
    d = reg_rdata;
    @(posedge clk);
    #1;
    check("rvalid drop", 16'(reg_rvalid), 16'h0000);
    check("rdata idle", reg_rdata, 16'h0000);
  endtask
  task automatic outs(input logic en, input logic [2:0] g, input logic [3:0] p,
    input logic [1:0] n);
    check("enable", 16'(step7_enable), 16'(en));
    check("skip", 16'(step7_skip), 16'(!en));
    check("gain", 16'(step7_gain), 16'(g));
    check("positive", 16'(step7_positive_input_select), 16'(p));
    check("negative", 16'(step7_negative_input_select), 16'(n));
  endtask
  task automatic reset_dut();
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // reset values, every field code, reserved bits, unmapped place, mid-run reset
  initial begin
    arst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reset_dut();
    outs(1'b0, GAIN_X1, 4'h7, NEG_GROUND);
    check("step8 out", step8_config, STEP8_RESET);
    rd(STEP8_ADDR, w);
    check("step8 read", w, STEP8_RESET);
    for (int i = 0; i < 16; i++) begin
      wr(STEP7_ADDR, {i[0], i[1:0], {8{i[0]}}, i[2], i[3:0]});
      outs(i[0], (i[1:0] == 2'h0) ? GAIN_X1 : (i[1:0] == 2'h1) ? GAIN_X2 : GAIN_X4, i[3:0],
        i[3] ? NEG_AUTO : i[2] ? NEG_AIN7 : NEG_GROUND);
      rd(STEP7_ADDR, w);
      check("step7 read", w, {i[0], i[1:0], 8'h00, i[2], i[3:0]});
    end
    wr(8'h99, 16'hFFFF);
    rd(8'h99, w);
    check("unmapped read", w, 16'h0000);
    wr(STEP8_ADDR, 16'h1234);
    check("step8 out", step8_config, 16'h1234 & WRITE_MASK);
    rd(STEP8_ADDR, w);
    check("step8 read", w, 16'h1234 & WRITE_MASK);
    rd(STEP7_ADDR, w);
    check("step7 kept", w, 16'hE01F);
    // read and write of one word in one cycle: the read sees the old word
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_rd <= 1'b1;
    reg_addr <= STEP7_ADDR;
    reg_wdata <= 16'h0000;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
    check("read beside write", reg_rdata, 16'hE01F);
    rd(STEP7_ADDR, w);
    check("write beside read", w, 16'h0000);
    reset_dut();
    rd(STEP7_ADDR, w);
    check("step7 reread", w, STEP7_RESET);
    outs(1'b0, GAIN_X1, 4'h7, NEG_GROUND);
    check("step8 reset out", step8_config, STEP8_RESET);
    end_sim();
  end
endmodule
